// ---- rtl/bdc_pkg.sv ----
// Shared constants for the three-phase bridge drive control block.
// Assumes a single 25 MHz clock and a plain strobe register port.
package bdc_pkg;
  localparam int CLK_MHZ = 25;
  localparam int EN_DLY_NS = 3000;
  localparam int DT_HI_NS = 3000;
  localparam int DT_LO_NS = 3000;
  // Least times round up to whole cycles
  localparam int EN_DLY_CYC = (EN_DLY_NS * CLK_MHZ + 999) / 1000;
  localparam int DT_HI_CYC = (DT_HI_NS * CLK_MHZ + 999) / 1000;
  localparam int DT_LO_CYC = (DT_LO_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CLEAR = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN = 8'h08;
  localparam logic [7:0] OFS_LIVE = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  // Error/status bit positions
  localparam int ST_CL = 0;
  localparam int ST_OT = 1;
  localparam int ST_OV = 2;
  localparam int ST_UV = 3;
  localparam int ST_FUSE = 4;
  localparam int ST_W = 5;
  // Synchroniser vector layout
  localparam int SY_LSE = 0;
  localparam int SY_HSE = 3;
  localparam int SY_M0 = 6;
  localparam int SY_M1 = 7;
  localparam int SY_PWM = 8;
  localparam int SY_CL = 9;
  localparam int SY_OT = 10;
  localparam int SY_OV = 11;
  localparam int SY_UV = 12;
  localparam int SY_FUSE = 13;
  localparam int SY_W = 14;
  // Control register
  localparam int CTRL_SOFT_OFF = 0;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [ST_W-1:0] IRQ_EN_RST = 5'h00;
  // Mode select encodings
  localparam logic [1:0] MODE_LOW_PWM = 2'h0;
  localparam logic [1:0] MODE_COMP_LSE = 2'h1;
  localparam logic [1:0] MODE_HIGH_PWM = 2'h2;
  localparam logic [1:0] MODE_COMP_HSE = 2'h3;
endpackage

// ---- rtl/bdc_dead_time.sv ----
// One phase of gate outputs with shoot-through dead time.
// Assumes the request pair is never both high at once.
`timescale 1ns/1ps
module bdc_dead_time #(
  parameter logic [7:0] HI_DLY = 8'(bdc_pkg::DT_HI_CYC),
  parameter logic [7:0] LO_DLY = 8'(bdc_pkg::DT_LO_CYC)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Requests
  input wire logic allow_i,
  input wire logic req_hi_i,
  input wire logic req_lo_i,
  // Gates
  output logic gate_hi_o,
  output logic gate_lo_o
);
  typedef struct packed {
    logic [7:0] cnt;
    logic hi;
    logic lo;
  } bdc_dt_st_t;

  bdc_dt_st_t s_ff;
  bdc_dt_st_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (!allow_i) begin
      nxt_s = '0;
    end else begin
      // Turn-off is immediate, turn-on waits for the dead time
      if (!req_hi_i) nxt_s.hi = 1'b0;
      if (!req_lo_i) nxt_s.lo = 1'b0;
      if (req_hi_i && !s_ff.hi && !nxt_s.lo) begin
        if (s_ff.cnt >= HI_DLY - 8'h01) begin
          nxt_s.hi = 1'b1;
          nxt_s.cnt = 8'h00;
        end else begin
          nxt_s.cnt = s_ff.cnt + 8'h01;
        end
      end else if (req_lo_i && !s_ff.lo && !nxt_s.hi) begin
        if (s_ff.cnt >= LO_DLY - 8'h01) begin
          nxt_s.lo = 1'b1;
          nxt_s.cnt = 8'h00;
        end else begin
          nxt_s.cnt = s_ff.cnt + 8'h01;
        end
      end else begin
        nxt_s.cnt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign gate_hi_o = s_ff.hi;
  assign gate_lo_o = s_ff.lo;
endmodule

// ---- rtl/bdc_drive_ctrl.sv ----
// Top of the three-phase bridge drive control logic.
// Assumes synchronous-ish pins, re-synchronised here, and a strobe register port.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module bdc_drive_ctrl #(
  parameter logic [7:0] EN_DLY = 8'(bdc_pkg::EN_DLY_CYC),
  parameter logic [7:0] HI_DLY = 8'(bdc_pkg::DT_HI_CYC),
  parameter logic [7:0] LO_DLY = 8'(bdc_pkg::DT_LO_CYC)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Phase enables, mode and PWM
  input wire logic [2:0] low_side_phase_enable_i,
  input wire logic [2:0] high_side_phase_enable_i,
  input wire logic mode_select_bit0_i,
  input wire logic mode_select_bit1_i,
  input wire logic pwm_i,
  // Fault indications
  input wire logic current_sense_trip_i,
  input wire logic overtemp_i,
  input wire logic overvolt_i,
  input wire logic supply_low_i,
  input wire logic fuse_blown_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  // Gate drives
  output logic high_gate_out_phase1_o,
  output logic high_gate_out_phase2_o,
  output logic high_gate_out_phase3_o,
  output logic low_gate_out_phase1_o,
  output logic low_gate_out_phase2_o,
  output logic low_gate_out_phase3_o
);
  typedef struct packed {
    logic [bdc_pkg::SY_W-1:0] sy1;
    logic [bdc_pkg::SY_W-1:0] sy2;
    logic pwm_d;
    logic [7:0] dly;
    logic por;
    logic flt;
    logic cl;
    logic fuse;
    logic [bdc_pkg::ST_W-1:0] status;
    logic [bdc_pkg::ST_W-1:0] irq_en;
    logic soft_off;
    logic allow;
    logic [2:0] req_hi;
    logic [2:0] req_lo;
    logic irq;
    logic [31:0] rdata;
  } bdc_st_t;

  bdc_st_t s_ff;
  bdc_st_t nxt_s;
  logic [2:0] gate_hi;
  logic [2:0] gate_lo;
  logic [bdc_pkg::SY_W-1:0] raw;

  // Truth table decode of one pair, returns {low, high}
  function automatic logic [1:0] pair_decode(input logic [1:0] md, input logic pwm,
      input logic cl, input logic flt, input logic low_side_phase_enable, input logic high_side_phase_enable);
    logic [1:0] r;
    r = 2'b00;
    if (flt || (low_side_phase_enable == high_side_phase_enable)) begin
      r = 2'b00;
    end else begin
      case (md)
        bdc_pkg::MODE_LOW_PWM: begin
          r = high_side_phase_enable ? 2'b01 : {pwm & ~cl, 1'b0};
        end
        bdc_pkg::MODE_COMP_LSE: begin
          r = high_side_phase_enable ? 2'b01 : (cl ? 2'b01 : {pwm, ~pwm});
        end
        bdc_pkg::MODE_HIGH_PWM: begin
          r = high_side_phase_enable ? {1'b0, pwm & ~cl} : 2'b10;
        end
        default: begin
          r = high_side_phase_enable ? (cl ? 2'b10 : {~pwm, pwm}) : 2'b10;
        end
      endcase
    end
    return r;
  endfunction

  assign raw = {fuse_blown_i, supply_low_i, overvolt_i, overtemp_i, current_sense_trip_i,
                pwm_i, mode_select_bit1_i, mode_select_bit0_i,
                high_side_phase_enable_i, low_side_phase_enable_i};

  always_comb begin
    logic pwm;
    logic edge_seen;
    logic rise;
    logic ot;
    logic ov;
    logic uv;
    logic clt;
    logic [1:0] md;
    logic [1:0] pr;
    logic [bdc_pkg::ST_W-1:0] ev;
    pr = 2'b00;
    nxt_s = s_ff;
    nxt_s.sy1 = raw;
    nxt_s.sy2 = s_ff.sy1;
    pwm = s_ff.sy2[bdc_pkg::SY_PWM];
    ot = s_ff.sy2[bdc_pkg::SY_OT];
    ov = s_ff.sy2[bdc_pkg::SY_OV];
    uv = s_ff.sy2[bdc_pkg::SY_UV];
    clt = s_ff.sy2[bdc_pkg::SY_CL];
    md = {s_ff.sy2[bdc_pkg::SY_M1], s_ff.sy2[bdc_pkg::SY_M0]};
    nxt_s.pwm_d = pwm;
    edge_seen = pwm ^ s_ff.pwm_d;
    rise = pwm & ~s_ff.pwm_d;
    // Enable delay restarts on every PWM edge
    if (edge_seen) begin
      nxt_s.dly = EN_DLY;
    end else if (s_ff.dly != 8'h00) begin
      nxt_s.dly = s_ff.dly - 8'h01;
    end
    // Toggle needed after power-up, supply dip, OT or OV
    if (uv || ot || ov) begin
      nxt_s.por = 1'b1;
    end else if (edge_seen) begin
      nxt_s.por = 1'b0;
    end
    // Fault latches release only at the start of a PWM cycle
    if (ot || ov) begin
      nxt_s.flt = 1'b1;
    end else if (rise) begin
      nxt_s.flt = 1'b0;
    end
    if (clt) begin
      nxt_s.cl = 1'b1;
    end else if (rise) begin
      nxt_s.cl = 1'b0;
    end
    // No way back from a blown fuse short of a full reset
    if (s_ff.sy2[bdc_pkg::SY_FUSE]) nxt_s.fuse = 1'b1;
    // Live OV and OT shut down at once, besides the latch
    nxt_s.allow = !s_ff.fuse && !uv && !ov && !ot && !s_ff.por && !s_ff.flt
                  && (s_ff.dly == 8'h00) && !s_ff.soft_off;
    for (int i = 0; i < 3; i++) begin
      pr = pair_decode(md, pwm, s_ff.cl, s_ff.flt || s_ff.fuse,
                       s_ff.sy2[bdc_pkg::SY_LSE + i],
                       s_ff.sy2[bdc_pkg::SY_HSE + i]);
      nxt_s.req_lo[i] = pr[1];
      nxt_s.req_hi[i] = pr[0];
    end
    // Sticky status: a new event beats a clear in the same cycle
    ev = '0;
    ev[bdc_pkg::ST_CL] = clt;
    ev[bdc_pkg::ST_OT] = ot;
    ev[bdc_pkg::ST_OV] = ov;
    ev[bdc_pkg::ST_UV] = uv;
    ev[bdc_pkg::ST_FUSE] = s_ff.fuse;
    nxt_s.status = s_ff.status | ev;
    nxt_s.rdata = 32'h0000_0000;
    if (wr_i) begin
      if (addr_i == bdc_pkg::OFS_CLEAR) begin
        nxt_s.status = (s_ff.status & ~wdata_i[bdc_pkg::ST_W-1:0]) | ev;
      end else if (addr_i == bdc_pkg::OFS_IRQ_EN) begin
        nxt_s.irq_en = wdata_i[bdc_pkg::ST_W-1:0];
      end else if (addr_i == bdc_pkg::OFS_CTRL) begin
        nxt_s.soft_off = wdata_i[bdc_pkg::CTRL_SOFT_OFF];
      end
    end
    if (rd_i) begin
      if (addr_i == bdc_pkg::OFS_STATUS) begin
        nxt_s.rdata = {27'h0, s_ff.status};
      end else if (addr_i == bdc_pkg::OFS_IRQ_EN) begin
        nxt_s.rdata = {27'h0, s_ff.irq_en};
      end else if (addr_i == bdc_pkg::OFS_LIVE) begin
        nxt_s.rdata = {16'h0, 2'h0, gate_lo, gate_hi, 3'h0, s_ff.allow,
                       s_ff.fuse, s_ff.por, s_ff.flt, s_ff.cl};
      end else if (addr_i == bdc_pkg::OFS_CTRL) begin
        nxt_s.rdata = {31'h0, s_ff.soft_off};
      end
    end
    nxt_s.irq = |(nxt_s.status & nxt_s.irq_en);
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_ff <= '0;
      s_ff.por <= 1'b1;
      s_ff.soft_off <= bdc_pkg::CTRL_RST;
      s_ff.irq_en <= bdc_pkg::IRQ_EN_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // The allow/request register and the final gate stage both register, so a fault costs two cycles of latency
  for (genvar p = 0; p < 3; p++) begin : g_phase
    bdc_dead_time #(
      .HI_DLY(HI_DLY),
      .LO_DLY(LO_DLY)
    ) u_dt (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .allow_i(s_ff.allow),
      .req_hi_i(s_ff.req_hi[p]),
      .req_lo_i(s_ff.req_lo[p]),
      .gate_hi_o(gate_hi[p]),
      .gate_lo_o(gate_lo[p])
    );
  end

  assign high_gate_out_phase1_o = gate_hi[0];
  assign high_gate_out_phase2_o = gate_hi[1];
  assign high_gate_out_phase3_o = gate_hi[2];
  assign low_gate_out_phase1_o = gate_lo[0];
  assign low_gate_out_phase2_o = gate_lo[1];
  assign low_gate_out_phase3_o = gate_lo[2];
  assign rdata_o = s_ff.rdata;
  assign irq_o = s_ff.irq;

  wire all_off = (gate_hi == 3'h0) && (gate_lo == 3'h0);
  wire pwm_edge = s_ff.sy2[bdc_pkg::SY_PWM] ^ s_ff.pwm_d;
  wire pwm_rise = s_ff.sy2[bdc_pkg::SY_PWM] & ~s_ff.pwm_d;

  sequence seq_edge;
    pwm_edge;
  endsequence
  sequence seq_held_off;
    all_off [*7];
  endsequence

  AST_EN_DELAY: assert property (@(posedge clk_i) disable iff (!resetn_i)
    seq_edge |-> ##3 seq_held_off) else $error("gates on too soon after PWM edge");
  AST_NO_SHOOT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(gate_hi[0]) |-> $past(!gate_lo[0], 1) && $past(!gate_lo[0], 2))
    else $error("high side turned on without dead time");
  AST_FLT_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_ff.flt && !pwm_rise |=> s_ff.flt) else $error("fault latch released mid cycle");
  AST_CL_LATCH: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_ff.sy2[bdc_pkg::SY_CL] |=> s_ff.cl && s_ff.status[bdc_pkg::ST_CL])
    else $error("current limit not latched");
  AST_POR_WAIT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_ff.por && !pwm_edge |=> s_ff.por) else $error("drive re-armed without PWM toggle");
  AST_OV_OFF: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_ff.sy2[bdc_pkg::SY_OV] |-> ##2 all_off) else $error("outputs on during overvoltage");
  AST_UV_OFF: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_ff.sy2[bdc_pkg::SY_UV] |-> ##2 all_off) else $error("outputs on with low supply");
  AST_OT_OFF: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_ff.sy2[bdc_pkg::SY_OT] |=> s_ff.status[bdc_pkg::ST_OT] ##1 all_off)
    else $error("overtemperature did not shut down");
  AST_FUSE_OFF: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_ff.fuse |-> ##2 (s_ff.fuse && all_off)) else $error("outputs on after fuse blown");
endmodule

// ---- bench/bdc_mcu_model.sv ----
// Behavioural controller that drives phase enables, mode selects and PWM.
// Assumes the bench calls its tasks; every pin changes just after a rising edge.
`timescale 1ns/1ps
module bdc_mcu_model (
  // Clock
  input wire logic clk_i,
  // Drive pins
  output logic [2:0] lse_o,
  output logic [2:0] hse_o,
  output logic [1:0] mode_o,
  output logic pwm_o
);
  initial begin
    lse_o = 3'h0;
    hse_o = 3'h0;
    mode_o = 2'h0;
    pwm_o = 1'b0;
  end

  task automatic set_pins(input logic [2:0] low_side_phase_enable, input logic [2:0] high_side_phase_enable, input logic [1:0] mode);
    @(posedge clk_i);
    lse_o <= low_side_phase_enable;
    hse_o <= high_side_phase_enable;
    mode_o <= mode;
  endtask

  // One call is one PWM edge; drives stay off after reset or UV until one comes, after OT or OV until a rising one
  task automatic toggle_pwm();
    @(posedge clk_i);
    pwm_o <= ~pwm_o;
  endtask
endmodule

// ---- bench/bdc_drive_ctrl_tb.sv ----
// Self-checking bench for the bridge drive control block.
// Assumes small delay parameters so each scenario settles in tens of cycles.
`timescale 1ns/1ps
module bdc_drive_ctrl_tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [4:0] flt = 5'h00;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic [2:0] low_side_phase_enable;
  logic [2:0] high_side_phase_enable;
  logic [1:0] mode;
  logic pwm;
  logic h1, h2, h3, l1, l2, l3;
  wire logic [5:0] gv = {l3, h3, l2, h2, l1, h1};
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;

  always #20 clk_i = ~clk_i;

  bdc_mcu_model bdc_mcu_model_i (.clk_i(clk_i), .lse_o(low_side_phase_enable), .hse_o(high_side_phase_enable), .mode_o(mode),
    .pwm_o(pwm));

  // Short delays keep the run brief; expectations use settle margins, not exact counts
  bdc_drive_ctrl #(.EN_DLY(8'h04), .HI_DLY(8'h04), .LO_DLY(8'h04)) bdc_drive_ctrl_i (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .low_side_phase_enable_i(low_side_phase_enable), .high_side_phase_enable_i(high_side_phase_enable),
    .mode_select_bit0_i(mode[0]), .mode_select_bit1_i(mode[1]), .pwm_i(pwm),
    .current_sense_trip_i(flt[bdc_pkg::ST_CL]), .overtemp_i(flt[bdc_pkg::ST_OT]),
    .overvolt_i(flt[bdc_pkg::ST_OV]), .supply_low_i(flt[bdc_pkg::ST_UV]),
    .fuse_blown_i(flt[bdc_pkg::ST_FUSE]),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
    .high_gate_out_phase1_o(h1), .high_gate_out_phase2_o(h2), .high_gate_out_phase3_o(h3),
    .low_gate_out_phase1_o(l1), .low_gate_out_phase2_o(l2), .low_gate_out_phase3_o(l3));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Sampling at the falling edge keeps registered outputs away from races
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Phase 1 low enable, phase 2 high enable, phase 3 both enables
  function automatic logic [5:0] exp_gates(input logic [1:0] m, input logic p);
    case (m)
      bdc_pkg::MODE_LOW_PWM: exp_gates = {2'b00, 2'b01, p, 1'b0};
      bdc_pkg::MODE_COMP_LSE: exp_gates = {2'b00, 2'b01, p, ~p};
      bdc_pkg::MODE_HIGH_PWM: exp_gates = {2'b00, 1'b0, p, 2'b10};
      default: exp_gates = {2'b00, ~p, p, 2'b10};
    endcase
  endfunction

  task automatic run_startup();
    logic [31:0] d;
    bdc_mcu_model_i.set_pins(3'b001, 3'b010, bdc_pkg::MODE_LOW_PWM);
    settle(40);
    check("gates_before_toggle", 32'(gv), 32'h0);
    reg_rd(bdc_pkg::OFS_IRQ_EN, d);
    check("irq_en_reset", d, 32'h0);
    reg_wr(bdc_pkg::OFS_IRQ_EN, 32'h1F);
    reg_rd(bdc_pkg::OFS_IRQ_EN, d);
    check("irq_en_rw", d, 32'h1F);
    reg_rd(8'h20, d);
    check("unmapped_read", d, 32'h0);
  endtask

  task automatic run_modes();
    for (int m = 0; m < 4; m++) begin
      bdc_mcu_model_i.set_pins(3'b101, 3'b110, 2'(m));
      for (int k = 0; k < 2; k++) begin
        bdc_mcu_model_i.toggle_pwm();
        settle(5);
        check("gates_after_edge", 32'(gv), 32'h0);
        settle(30);
        check("gates_mode", 32'(gv), 32'(exp_gates(2'(m), pwm)));
      end
    end
  endtask

  task automatic pwm_high();
    bdc_mcu_model_i.toggle_pwm();
    settle(2);
    bdc_mcu_model_i.toggle_pwm();
    settle(2);
    if (pwm !== 1'b1)
      bdc_mcu_model_i.toggle_pwm();
    settle(40);
  endtask

  task automatic run_fault(input int b);
    logic [31:0] d;
    logic [5:0] held;
    held = (b == bdc_pkg::ST_CL) ? 6'h04 : 6'h00;
    bdc_mcu_model_i.set_pins(3'b001, 3'b010, bdc_pkg::MODE_LOW_PWM);
    pwm_high();
    check("gates_run", 32'(gv), 32'h06);
    @(posedge clk_i);
    flt[b] <= 1'b1;
    settle(10);
    check("gates_fault", 32'(gv), 32'(held));
    reg_rd(bdc_pkg::OFS_STATUS, d);
    check("status_bit", (d >> b) & 32'h1, 32'h1);
    check("irq_set", 32'(irq), 32'h1);
    if (b == bdc_pkg::ST_CL) begin
      reg_wr(bdc_pkg::OFS_IRQ_EN, 32'h0);
      settle(2);
      check("irq_masked", 32'(irq), 32'h0);
      reg_wr(bdc_pkg::OFS_IRQ_EN, 32'h1F);
    end
    @(posedge clk_i);
    flt[b] <= 1'b0;
    settle(20);
    if (b != bdc_pkg::ST_UV)
      check("gates_latched", 32'(gv), 32'(held));
    if (b != bdc_pkg::ST_FUSE) begin
      reg_wr(bdc_pkg::OFS_CLEAR, 32'(1 << b));
      settle(2);
      check("irq_cleared", 32'(irq), 32'h0);
    end
    pwm_high();
    held = (b == bdc_pkg::ST_FUSE) ? 6'h00 : 6'h06;
    check("gates_resume", 32'(gv), 32'(held));
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    run_startup();
    run_modes();
    for (int b = 0; b < bdc_pkg::ST_W; b++)
      run_fault(b);
    complete_run();
  end
endmodule
